// ---- hdl/brg_top.sv ----
// baud-rate generator with prescaler, reload timer, fractional divider and timer-1 source
// assumes a same-clock register master and a serial unit consuming the tick pulses
//
// What this block does
// - baud is clock/(16*2^sel*(reload+1)); reload 0 at sel 0 runs as reload 1
// - fractional divider scales baud by step/256
// - baud never exceeds clock over 32
// - prescale divides by two to its code
// - timer-one baud uses double bit, high byte
// - divider mode stops baud generation unless timer one is the source
// - divider mode: 8-bit up-counting reload timer
// - result reads count; step is reload value
// - each overflow sets flag, raises interrupt
// - divider output is input over 256-step
// - slow links use prescaler only
// - control: enable bit0, mode bit1, flag bit2
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ns

`include "brg_cfg.svh"

module brg_top
    import brg_pkg::*;
(
    // clock, reset, enable
    input wire logic CLK_I,
    input wire logic RESETN_I,
    input wire logic CE_I,
    // register port
    input wire brg_bus_req_t BUS_I,
    output logic [7:0] RDATA_O,
    // baud ticks to the serial unit
    output logic BAUD_X16_O,
    output logic BAUD_TICK_O,
    // divider mode outputs
    output logic DIV_CLK_O,
    output logic DIV_IRQ_O
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------

    brg_top_state_t s_q;
    brg_top_state_t s_d;

    logic [6:0] pre_mask;
    logic pre_tick;
    logic [7:0] br_eff;
    logic timer_tick;
    logic t1_ovf;
    logic t1_x16;
    logic raw_x16;
    logic frac_tick;
    logic div_ovf;
    logic [7:0] div_result;
    logic [7:0] rd_mux;

    // ------------------------------------------------------------
    // fractional divider
    // ------------------------------------------------------------

    brg_frac_div u_frac_div
    (
        .clk_i(CLK_I),
        .resetn_i(RESETN_I),
        .ce_i(CE_I),
        .tick_i(timer_tick),
        .divider_enable_i(s_q.divider_enable),
        .fdm_i(s_q.divider_mode_select),
        .step_i(s_q.step),
        .result_o(div_result),
        .tick_o(frac_tick),
        .ovf_o(div_ovf)
    );

    // ------------------------------------------------------------
    // read multiplexer
    // ------------------------------------------------------------

    always_comb
    begin
        rd_mux = `BRG_ZERO8;
        case (BUS_I.addr)
            `BRG_OFS_BAUD_CTRL:
            begin
                rd_mux[`BRG_BIT_RUN] = s_q.run;
                rd_mux[`BRG_PRE_MSB:`BRG_PRE_LSB] = s_q.pre_sel;
            end
            `BRG_OFS_BAUD_RELOAD:
            begin
                rd_mux = s_q.reload;
            end
            `BRG_OFS_FD_CTRL:
            begin
                rd_mux[`BRG_BIT_DIVIDER_ENABLE] = s_q.divider_enable;
                rd_mux[`BRG_BIT_FDM] = s_q.divider_mode_select;
                rd_mux[`BRG_BIT_DIVIDER_OVERFLOW_FLAG] = s_q.ovf_flag;
            end
            `BRG_OFS_FD_STEP:
            begin
                rd_mux = s_q.step;
            end
            `BRG_OFS_FD_RESULT:
            begin
                rd_mux = div_result;
            end
            `BRG_OFS_T1_CTRL:
            begin
                rd_mux[`BRG_BIT_T1SRC] = s_q.t1_src;
                rd_mux[`BRG_BIT_DOUBLE] = s_q.dbl;
            end
            `BRG_OFS_T1_HIGH:
            begin
                rd_mux = s_q.t1_high;
            end
            default:
            begin
                rd_mux = `BRG_ZERO8;
            end
        endcase
    end

    // ------------------------------------------------------------
    // prescaler and reload timer
    // ------------------------------------------------------------

    always_comb
    begin
        // mask is 2^sel-1, so a tick falls every 2^sel cycles
        pre_mask = ~(`BRG_PRE_FULL << s_q.pre_sel);
        pre_tick = (s_q.pre_cnt & pre_mask) == pre_mask;
        // a total divide of one would break the clock/32 ceiling, so it runs as two
        if ((s_q.pre_sel == `BRG_RST_PRE) && (s_q.reload == `BRG_ZERO8))
        begin
            br_eff = `BRG_ONE8;
        end
        else
        begin
            br_eff = s_q.reload;
        end
        timer_tick = s_q.run & ~s_q.t1_src & pre_tick & (s_q.br_cnt == `BRG_ZERO8);
    end

    // ------------------------------------------------------------
    // timer-one source
    // ------------------------------------------------------------

    always_comb
    begin
        // timer one counts every second clock and reloads from its high byte
        t1_ovf = s_q.t1_src & s_q.t1_half & (s_q.t1_cnt == `BRG_TOP8);
        // without the double bit every second overflow is a sample tick
        if (s_q.dbl)
        begin
            t1_x16 = t1_ovf;
        end
        else
        begin
            t1_x16 = t1_ovf & s_q.t1_ovf_half;
        end
        if (s_q.t1_src)
        begin
            raw_x16 = t1_x16;
        end
        else
        begin
            // only the prescaler path when the divider is off
            raw_x16 = frac_tick;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------

    always_comb
    begin
        s_d = s_q;

        // prescaler and reload timer
        if (s_q.run && !s_q.t1_src)
        begin
            s_d.pre_cnt = s_q.pre_cnt + `BRG_PRE_ONE;
            if (pre_tick)
            begin
                if (s_q.br_cnt == `BRG_ZERO8)
                begin
                    s_d.br_cnt = br_eff;
                end
                else
                begin
                    s_d.br_cnt = s_q.br_cnt - `BRG_ONE8;
                end
            end
        end
        else
        begin
            s_d.pre_cnt = `BRG_PRE_ZERO;
            s_d.br_cnt = br_eff;
        end

        // timer one
        if (s_q.t1_src)
        begin
            s_d.t1_half = ~s_q.t1_half;
            if (s_q.t1_half)
            begin
                if (s_q.t1_cnt == `BRG_TOP8)
                begin
                    s_d.t1_cnt = s_q.t1_high;
                end
                else
                begin
                    s_d.t1_cnt = s_q.t1_cnt + `BRG_ONE8;
                end
            end
            if (t1_ovf)
            begin
                s_d.t1_ovf_half = ~s_q.t1_ovf_half;
            end
        end
        else
        begin
            s_d.t1_half = 1'b0;
            s_d.t1_ovf_half = 1'b0;
            s_d.t1_cnt = s_q.t1_high;
        end

        // sixteen sample ticks make one bit tick
        if (raw_x16)
        begin
            if (s_q.ovs_cnt == `BRG_OVS_LAST)
            begin
                s_d.ovs_cnt = `BRG_OVS_ZERO;
            end
            else
            begin
                s_d.ovs_cnt = s_q.ovs_cnt + `BRG_OVS_ONE;
            end
        end
        s_d.x16 = raw_x16;
        s_d.baud = raw_x16 & (s_q.ovs_cnt == `BRG_OVS_LAST);

        // divider mode outputs
        s_d.div_clk = div_ovf;
        s_d.irq = div_ovf;

        // register writes
        if (BUS_I.wr)
        begin
            case (BUS_I.addr)
                `BRG_OFS_BAUD_CTRL:
                begin
                    s_d.run = BUS_I.wdata[`BRG_BIT_RUN];
                    s_d.pre_sel = BUS_I.wdata[`BRG_PRE_MSB:`BRG_PRE_LSB];
                end
                `BRG_OFS_BAUD_RELOAD:
                begin
                    s_d.reload = BUS_I.wdata;
                end
                `BRG_OFS_FD_CTRL:
                begin
                    s_d.divider_enable = BUS_I.wdata[`BRG_BIT_DIVIDER_ENABLE];
                    s_d.divider_mode_select = BUS_I.wdata[`BRG_BIT_FDM];
                    s_d.ovf_flag = BUS_I.wdata[`BRG_BIT_DIVIDER_OVERFLOW_FLAG];
                end
                `BRG_OFS_FD_STEP:
                begin
                    s_d.step = BUS_I.wdata;
                end
                `BRG_OFS_T1_CTRL:
                begin
                    s_d.t1_src = BUS_I.wdata[`BRG_BIT_T1SRC];
                    s_d.dbl = BUS_I.wdata[`BRG_BIT_DOUBLE];
                end
                `BRG_OFS_T1_HIGH:
                begin
                    s_d.t1_high = BUS_I.wdata;
                end
                default:
                begin
                    s_d.reload = s_q.reload;
                end
            endcase
        end

        // an overflow in the clearing cycle still sets the flag
        if (div_ovf)
        begin
            s_d.ovf_flag = 1'b1;
        end

        // read data stands for the one cycle after the strobe only
        if (BUS_I.rd)
        begin
            s_d.rdata = rd_mux;
        end
        else
        begin
            s_d.rdata = `BRG_ZERO8;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------

    always_ff @(posedge CLK_I)
    begin
        if (!RESETN_I)
        begin
            s_q.rdata <= `BRG_RST8;
            s_q.run <= 1'b0;
            s_q.pre_sel <= `BRG_RST_PRE;
            s_q.reload <= `BRG_RST8;
            s_q.divider_enable <= 1'b0;
            s_q.divider_mode_select <= 1'b0;
            s_q.ovf_flag <= 1'b0;
            s_q.step <= `BRG_RST8;
            s_q.t1_src <= 1'b0;
            s_q.dbl <= 1'b0;
            s_q.t1_high <= `BRG_RST8;
            s_q.pre_cnt <= `BRG_PRE_ZERO;
            s_q.br_cnt <= `BRG_RST8;
            s_q.t1_cnt <= `BRG_RST8;
            s_q.t1_half <= 1'b0;
            s_q.t1_ovf_half <= 1'b0;
            s_q.ovs_cnt <= `BRG_OVS_ZERO;
            s_q.x16 <= 1'b0;
            s_q.baud <= 1'b0;
            s_q.div_clk <= 1'b0;
            s_q.irq <= 1'b0;
        end
        else if (CE_I)
        begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------

    assign RDATA_O = s_q.rdata;
    assign BAUD_X16_O = s_q.x16;
    assign BAUD_TICK_O = s_q.baud;
    assign DIV_CLK_O = s_q.div_clk;
    assign DIV_IRQ_O = s_q.irq;

endmodule : brg_top

// ---- hdl/brg_cfg.svh ----
// register offsets, field positions, reset values and counts for the baud generator
// assumes an 8-bit register port and a single peripheral clock
`ifndef BRG_CFG_SVH
`define BRG_CFG_SVH

// register offsets
`define BRG_OFS_BAUD_CTRL 8'hbd
`define BRG_OFS_BAUD_RELOAD 8'hbe
`define BRG_OFS_FD_CTRL 8'he9
`define BRG_OFS_FD_STEP 8'hea
`define BRG_OFS_FD_RESULT 8'heb
`define BRG_OFS_T1_CTRL 8'hc8
`define BRG_OFS_T1_HIGH 8'hc9

// field positions
`define BRG_BIT_RUN 0
`define BRG_PRE_LSB 1
`define BRG_PRE_MSB 3
`define BRG_BIT_DIVIDER_ENABLE 0
`define BRG_BIT_FDM 1
`define BRG_BIT_DIVIDER_OVERFLOW_FLAG 2
`define BRG_BIT_T1SRC 0
`define BRG_BIT_DOUBLE 1

// reset values and counts
`define BRG_RST8 8'h00
`define BRG_RST_PRE 3'h0
`define BRG_ZERO8 8'h00
`define BRG_ONE8 8'h01
`define BRG_TOP8 8'hff
`define BRG_PRE_FULL 7'h7f
`define BRG_PRE_ZERO 7'h00
`define BRG_PRE_ONE 7'h01
`define BRG_OVS_ZERO 4'h0
`define BRG_OVS_ONE 4'h1
`define BRG_OVS_LAST 4'hf

`endif

// ---- hdl/brg_pkg.sv ----
// types shared by the baud generator and its fractional divider
// assumes brg_cfg.svh supplies all numeric constants
package brg_pkg;

    // one register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } brg_bus_req_t;

    // all state of the top module
    typedef struct packed {
        logic [7:0] rdata;
        logic run;
        logic [2:0] pre_sel;
        logic [7:0] reload;
        logic divider_enable;
        logic divider_mode_select;
        logic ovf_flag;
        logic [7:0] step;
        logic t1_src;
        logic dbl;
        logic [7:0] t1_high;
        logic [6:0] pre_cnt;
        logic [7:0] br_cnt;
        logic [7:0] t1_cnt;
        logic t1_half;
        logic t1_ovf_half;
        logic [3:0] ovs_cnt;
        logic x16;
        logic baud;
        logic div_clk;
        logic irq;
    } brg_top_state_t;

    // all state of the fractional divider
    typedef struct packed {
        logic [7:0] cnt;
    } brg_div_state_t;

endpackage : brg_pkg

// ---- hdl/brg_frac_div.sv ----
// fractional divider: baud refinement or stand-alone 8-bit auto-reload timer
// assumes tick_i is a one-cycle pulse on the same clock
`timescale 1ns/1ns

`include "brg_cfg.svh"

module brg_frac_div
    import brg_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // control
    input wire logic tick_i,
    input wire logic divider_enable_i,
    input wire logic fdm_i,
    input wire logic [7:0] step_i,
    // results
    output logic [7:0] result_o,
    output logic tick_o,
    output logic ovf_o
);

    brg_div_state_t s_q;
    brg_div_state_t s_d;
    logic [8:0] sum;

    always_comb
    begin
        s_d = s_q;
        tick_o = 1'b0;
        ovf_o = 1'b0;
        sum = {1'b0, s_q.cnt} + {1'b0, step_i};
        if (!divider_enable_i)
        begin
            // counter holds; baud ticks pass unscaled when not in divider mode
            tick_o = tick_i & ~fdm_i;
        end
        else if (fdm_i)
        begin
            // free timer on the peripheral clock; no baud ticks at all
            if (s_q.cnt == `BRG_TOP8)
            begin
                s_d.cnt = step_i;
                ovf_o = 1'b1;
            end
            else
            begin
                s_d.cnt = s_q.cnt + `BRG_ONE8;
            end
        end
        else if (tick_i)
        begin
            // carry of the step accumulator gives step/256 of the input rate
            s_d.cnt = sum[7:0];
            tick_o = sum[8];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            s_q.cnt <= `BRG_RST8;
        end
        else if (ce_i)
        begin
            s_q <= s_d;
        end
    end

    assign result_o = s_q.cnt;

endmodule : brg_frac_div

// ---- test/brg_top_asserts.sv ----
// port checker for the baud generator top
// assumes it is bound to brg_top and sees its ports only
`timescale 1ns/1ns

`include "brg_cfg.svh"

module brg_top_asserts
    import brg_pkg::*;
(
    // clock and reset
    input wire logic CLK_I,
    input wire logic RESETN_I,
    input wire logic CE_I,
    // register port
    input wire brg_bus_req_t BUS_I,
    input wire logic [7:0] RDATA_O,
    // pulses
    input wire logic BAUD_X16_O,
    input wire logic BAUD_TICK_O,
    input wire logic DIV_CLK_O,
    input wire logic DIV_IRQ_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);

    // ------------------------------------------------
    // properties
    // ------------------------------------------------
    tick_on_x16_a: assert property (BAUD_TICK_O |-> BAUD_X16_O)
        else $error("baud tick without x16 pulse");
    x16_spacing_a: assert property (BAUD_X16_O && CE_I |=> !BAUD_X16_O)
        else $error("x16 pulses closer than two cycles");
    tick_spacing_a: assert property (BAUD_TICK_O && CE_I |=> !BAUD_TICK_O [*8])
        else $error("baud ticks too close");
    irq_with_clk_a: assert property ((DIV_CLK_O || DIV_IRQ_O) |-> (DIV_CLK_O && DIV_IRQ_O))
        else $error("divider request and output clock differ");
    div_stops_baud_a: assert property (DIV_CLK_O |-> !BAUD_X16_O)
        else $error("baud pulse while in divider mode");
    disabled_quiet_a: assert property (BUS_I.wr && CE_I && BUS_I.addr == `BRG_OFS_FD_CTRL
        && !BUS_I.wdata[`BRG_BIT_DIVIDER_ENABLE] ##1 (CE_I && !BUS_I.wr) [*3]
        |-> !DIV_CLK_O [*3])
        else $error("divider pulse after disable");
    read_idle_zero_a: assert property (CE_I && !BUS_I.rd |=> RDATA_O == 8'h00)
        else $error("read data outside read slot");
    ctrl_reserved_a: assert property (CE_I && BUS_I.rd && BUS_I.addr == `BRG_OFS_FD_CTRL
        |=> RDATA_O[7:3] == 5'h00)
        else $error("reserved control bits not zero");
    unmapped_zero_a: assert property (CE_I && BUS_I.rd && BUS_I.addr == 8'h00
        |=> RDATA_O == 8'h00)
        else $error("unmapped read not zero");
endmodule : brg_top_asserts

// ---- test/brg_serial_model.sv ----
// serial unit stand-in: consumes x16 and baud ticks
// assumes both pulses are one cycle wide on the same clock
`timescale 1ns/1ns

module brg_serial_model
(
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // ticks
    input wire logic x16_i,
    input wire logic tick_i,
    // tallies
    output logic [15:0] bits_o,
    output logic [15:0] bad_o
);
    logic [4:0] ovs_q;

    // a bit is exactly sixteen x16 pulses, the last one carrying the tick
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            ovs_q <= 5'h00;
            bits_o <= 16'h0000;
            bad_o <= 16'h0000;
        end
        else if (x16_i && tick_i)
        begin
            if (ovs_q != 5'h0f)
                bad_o <= bad_o + 16'h0001;
            ovs_q <= 5'h00;
            bits_o <= bits_o + 16'h0001;
        end
        else if (x16_i)
            ovs_q <= ovs_q + 5'h01;
    end
endmodule : brg_serial_model

// ---- test/brg_top_tb.sv ----
// self-checking bench for the baud generator
// assumes the header offsets and a 250 MHz clock
`timescale 1ns/1ns

`include "brg_cfg.svh"

module brg_top_tb
    import brg_pkg::*;
;
    logic clk, resetn, ce, x16, tick, div_clk, div_irq;
    brg_bus_req_t bus;
    logic [7:0] rdata;
    logic [15:0] bits, bad;
    int miscompares = 0;
    int check_count = 0;
    int cyc = 0;
    int seed = 32'hb556;
    logic [7:0] regs [8] = '{`BRG_OFS_BAUD_CTRL, `BRG_OFS_BAUD_RELOAD, `BRG_OFS_FD_CTRL,
        `BRG_OFS_FD_STEP, `BRG_OFS_FD_RESULT, `BRG_OFS_T1_CTRL, `BRG_OFS_T1_HIGH, 8'h00};

    brg_top u_brg_top (.CLK_I(clk), .RESETN_I(resetn), .CE_I(ce), .BUS_I(bus),
        .RDATA_O(rdata), .BAUD_X16_O(x16), .BAUD_TICK_O(tick), .DIV_CLK_O(div_clk),
        .DIV_IRQ_O(div_irq));
    brg_serial_model u_brg_serial_model (.clk_i(clk), .resetn_i(resetn), .x16_i(x16),
        .tick_i(tick), .bits_o(bits), .bad_o(bad));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ------------------------------------------------
    // tasks
    // ------------------------------------------------
    task automatic close_out();
        if (miscompares == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : close_out

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        @(negedge clk);
        d = rdata;
    endtask : rd

    task automatic gap(input bit dv, output int per);
        int n;
        n = 0;
        while ((dv ? div_clk : x16) !== 1'b1 && n < 3000)
        begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        per = 1;
        while ((dv ? div_clk : x16) !== 1'b1 && per < 3000)
        begin
            @(negedge clk);
            per++;
        end
    endtask : gap

    task automatic cnt(input bit dv, input int cycles, output int n);
        n = 0;
        repeat (cycles)
        begin
            @(negedge clk);
            if ((dv ? div_clk : x16) === 1'b1)
                n++;
        end
    endtask : cnt

    // hang guard: whole run is well under this
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            miscompares++;
            close_out();
        end
    end

    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial
    begin
        logic [7:0] d, r, s;
        int p, n, e;
        bus = '0;
        resetn = 1'b0;
        ce = 1'b1;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        foreach (regs[i])
        begin
            rd(regs[i], d);
            chk("reset value", 16'h0000, {8'h00, d});
        end
        r = 8'($random(seed));
        wr(`BRG_OFS_BAUD_RELOAD, r);
        rd(`BRG_OFS_BAUD_RELOAD, d);
        chk("reload readback", {8'h00, r}, {8'h00, d});
        wr(`BRG_OFS_FD_RESULT, 8'hff);
        rd(`BRG_OFS_FD_RESULT, d);
        chk("result read only", 16'h0000, {8'h00, d});
        for (int sel = 0; sel < 4; sel++)
        begin
            r = {5'h00, 3'($random(seed))};
            wr(`BRG_OFS_BAUD_RELOAD, r);
            wr(`BRG_OFS_BAUD_CTRL, {4'h0, 3'(sel), 1'b1});
            gap(1'b0, p);
            gap(1'b0, p);
            e = (1 << sel) * (r + 1);
            if (e == 1)
                e = 2;
            chk("x16 period", 16'(e), 16'(p));
        end
        s = 8'($random(seed)) | 8'h01;
        wr(`BRG_OFS_BAUD_RELOAD, 8'h01);
        wr(`BRG_OFS_BAUD_CTRL, 8'h01);
        wr(`BRG_OFS_FD_STEP, s);
        wr(`BRG_OFS_FD_CTRL, 8'h01);
        gap(1'b0, p);
        cnt(1'b0, 512, n);
        chk("fractional pulses", {8'h00, s}, 16'(n));
        s = {2'b11, 5'($random(seed)), 1'b0};
        wr(`BRG_OFS_FD_STEP, s);
        wr(`BRG_OFS_FD_CTRL, 8'h03);
        gap(1'b1, p);
        gap(1'b1, p);
        chk("divider period", 16'(256 - s), 16'(p));
        // one full divider period holds exactly one interrupt request
        n = 0;
        repeat (256 - s)
        begin
            @(negedge clk);
            if (div_irq === 1'b1)
                n++;
        end
        chk("irq per period", 16'h0001, 16'(n));
        cnt(1'b0, 200, n);
        chk("baud in divider mode", 16'h0000, 16'(n));
        rd(`BRG_OFS_FD_CTRL, d);
        chk("overflow flag", 16'h0007, {8'h00, d});
        wr(`BRG_OFS_FD_CTRL, 8'h02);
        rd(`BRG_OFS_FD_RESULT, d);
        chk("result from reload", 16'h0001, {15'h0000, d >= s});
        cnt(1'b1, 300, n);
        chk("disabled divider pulses", 16'h0000, 16'(n));
        rd(`BRG_OFS_FD_RESULT, r);
        chk("disabled count holds", {8'h00, d}, {8'h00, r});
        wr(`BRG_OFS_FD_CTRL, 8'h00);
        rd(`BRG_OFS_FD_CTRL, d);
        chk("flag cleared", 16'h0000, {8'h00, d});
        for (int dbl = 0; dbl < 2; dbl++)
        begin
            r = {4'hf, 3'($random(seed)), 1'b0};
            wr(`BRG_OFS_T1_HIGH, r);
            wr(`BRG_OFS_T1_CTRL, {6'h00, 1'(dbl), 1'b1});
            gap(1'b0, p);
            gap(1'b0, p);
            e = 4 * (256 - r) / (1 << dbl);
            chk("timer one x16 period", 16'(e), 16'(p));
        end
        repeat (2000) @(posedge clk);
        chk("bit ticks seen", 16'h0001, {15'h0000, bits > 0});
        chk("x16 per bit", 16'h0000, bad);
        close_out();
    end
endmodule : brg_top_tb

bind brg_top brg_top_asserts u_brg_top_asserts (.CLK_I(CLK_I), .RESETN_I(RESETN_I),
    .CE_I(CE_I), .BUS_I(BUS_I), .RDATA_O(RDATA_O), .BAUD_X16_O(BAUD_X16_O),
    .BAUD_TICK_O(BAUD_TICK_O), .DIV_CLK_O(DIV_CLK_O), .DIV_IRQ_O(DIV_IRQ_O));
